// *** mcr_pkg.sv ***
// Operation
// - Bank zero routes 0x80 upward to upper set.
// - Bank one routes 0x60 to 0x74 alternates.
// - Wait stretch multiplies the wait period by sixteen.
// - Sleep option stops oscillator, raises flag on interrupt.
// - Oscillator resumes once interrupts and flag cleared.
// - Go starts selected chain command, reset code two.
// - Flicker status change raises system interrupt when enabled.
// - Chain completion raises system interrupt when enabled.
// - Auto low power when every function idles.
package mcr_pkg;

  // Register byte addresses of the miscellaneous configuration bank.
  localparam logic [7:0] MCR_ADDR_CFG_ZERO = 8'hA9;
  localparam logic [7:0] MCR_ADDR_SLEEP_CTL = 8'hAC;
  localparam logic [7:0] MCR_ADDR_MUX_CFG = 8'hAF;
  localparam logic [7:0] MCR_ADDR_IRQ_EN = 8'hB2;

  // Address windows that the bank select steers between.
  localparam logic [7:0] MCR_UPPER_LO = 8'h80;
  localparam logic [7:0] MCR_ALT_LO = 8'h60;
  localparam logic [7:0] MCR_ALT_HI = 8'h74;

  // Field positions in misc_config_zero.
  localparam int MCR_BIT_LOW_POWER = 5;
  localparam int MCR_BIT_BANK_SEL = 4;
  localparam int MCR_BIT_WAIT_STRETCH = 2;

  // Field positions in sleep_control.
  localparam int MCR_BIT_SLEEP_ON_IRQ = 4;
  localparam int MCR_SLEEP_RSVD_MSB = 3;

  // Field positions in mux_command_config.
  localparam int MCR_MUX_CMD_MSB = 4;
  localparam int MCR_MUX_CMD_LSB = 3;

  // Field positions in system_irq_enable.
  localparam int MCR_BIT_FLICKER_IRQ_EN = 6;
  localparam int MCR_BIT_MUX_DONE_IRQ_EN = 4;

  // Reset value of the stored chain command and value of the reserved nibble.
  localparam logic [3:0] MCR_SLEEP_RSVD_VAL = 4'hC;
  localparam logic [1:0] MCR_MUX_CMD_RST = 2'h2;

  // Chain command encodings.
  localparam logic [1:0] MCR_CMD_ROM_INIT = 2'h0;
  localparam logic [1:0] MCR_CMD_READ_RAM = 2'h1;
  localparam logic [1:0] MCR_CMD_WRITE_CHAIN = 2'h2;
  localparam logic [1:0] MCR_CMD_RESERVED = 2'h3;

  // Wait period arithmetic: one step more than the setting, shifted when stretched.
  localparam int MCR_WAIT_SET_W = 8;
  localparam int MCR_WAIT_STEPS_W = 13;
  localparam int MCR_WAIT_STRETCH_SHIFT = 4;
  localparam logic [MCR_WAIT_STEPS_W-1:0] MCR_WAIT_ONE = 13'h0001;

  // State of the chain command sequencer.
  typedef enum logic {MCR_MUX_IDLE, MCR_MUX_BUSY} mcr_mux_st_t;

endpackage

// *** mcr_sleep_ctl.sv ***
`timescale 1ns/10ps
// Sleep-after-interrupt control: holds the oscillator off while the flag stands.
module mcr_sleep_ctl
  import mcr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic sleep_en,
  input wire logic irq_active,
  input wire logic flag_clr,
  output logic flag_r,
  output logic osc_run_r
);

  logic flag_nxt; // Next value of the sleep flag.
  logic osc_run_nxt; // Next value of the oscillator run request.

  // The set term wins over the clear, and a clear while an interrupt still
  // stands is ignored, so the oscillator can never restart with one pending.
  always_comb begin
    flag_nxt = flag_r;
    if (sleep_en && irq_active) begin
      flag_nxt = 1'b1;
    end else if (flag_clr && !irq_active) begin
      flag_nxt = 1'b0;
    end
    osc_run_nxt = !flag_nxt;
  end

  // Register the flag and the run request; clock enable low freezes both.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flag_r <= 1'b0;
      osc_run_r <= 1'b1;
    end else if (ce) begin
      flag_r <= flag_nxt;
      osc_run_r <= osc_run_nxt;
    end
  end

endmodule

// *** mcr_top.sv ***
`timescale 1ns/10ps
// Miscellaneous configuration bank of the sensor front end.
module mcr_top
  import mcr_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic CE,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  output logic REG_RD_VALID,
  output logic FWD_UPPER,
  output logic FWD_ALT,
  output logic [7:0] FWD_ADDR,
  output logic [7:0] FWD_WDATA,
  output logic FWD_WR,
  input wire logic [7:0] WAIT_TIME_SETTING,
  output logic [12:0] WAIT_STEPS,
  input wire logic IRQ_ACTIVE,
  input wire logic SLEEP_FLAG_CLR,
  output logic SLEEP_FLAG,
  output logic OSC_RUN,
  input wire logic MUX_GO_SET,
  input wire logic MUX_DONE,
  output logic MUX_START,
  output logic [1:0] MUX_CMD,
  output logic MUX_BUSY,
  input wire logic FLICKER_STATUS,
  output logic SYS_IRQ_FLICKER,
  output logic SYS_IRQ_MUX,
  input wire logic ALL_IDLE,
  output logic LOW_POWER_IDLE
);

  // True when the address names one of the four registers of this bank.
  // This bank answers whatever the bank select holds, so software can always
  // clear the select again; locking itself out would need a reset.
  function automatic logic is_own(input logic [7:0] addr);
    is_own = (addr == MCR_ADDR_CFG_ZERO) || (addr == MCR_ADDR_SLEEP_CTL) ||
             (addr == MCR_ADDR_MUX_CFG) || (addr == MCR_ADDR_IRQ_EN);
  endfunction

  // True when the address lies in the alternate window.
  function automatic logic in_alt(input logic [7:0] addr);
    in_alt = (addr >= MCR_ALT_LO) && (addr <= MCR_ALT_HI);
  endfunction

  // Stored configuration fields.
  logic low_power_r; // Auto low power idle enable.
  logic low_power_nxt;
  logic bank_sel_r; // Bank select: zero upper set, one alternate set.
  logic bank_sel_nxt;
  logic wait_stretch_r; // Wait period stretch by sixteen.
  logic wait_stretch_nxt;
  logic sleep_on_irq_r; // Sleep after interrupt enable.
  logic sleep_on_irq_nxt;
  logic [1:0] mux_cmd_cfg_r; // Chain command chosen for the next go.
  logic [1:0] mux_cmd_cfg_nxt;
  logic flicker_irq_en_r; // Flicker change interrupt enable.
  logic flicker_irq_en_nxt;
  logic mux_done_irq_en_r; // Chain completion interrupt enable.
  logic mux_done_irq_en_nxt;

  // Register access answer and forwarding strobes.
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic rd_valid_r;
  logic rd_valid_nxt;
  logic fwd_upper_r;
  logic fwd_upper_nxt;
  logic fwd_alt_r;
  logic fwd_alt_nxt;
  logic [7:0] fwd_addr_r;
  logic [7:0] fwd_addr_nxt;
  logic [7:0] fwd_wdata_r;
  logic [7:0] fwd_wdata_nxt;
  logic fwd_wr_r;
  logic fwd_wr_nxt;

  // Decoded access terms.
  logic access; // A read or write is requested this cycle.
  logic own_hit; // The request names a register of this bank.

  // Configuration register write and read path.
  always_comb begin
    access = REG_WR || REG_RD;
    own_hit = is_own(REG_ADDR);
    low_power_nxt = low_power_r;
    bank_sel_nxt = bank_sel_r;
    wait_stretch_nxt = wait_stretch_r;
    sleep_on_irq_nxt = sleep_on_irq_r;
    mux_cmd_cfg_nxt = mux_cmd_cfg_r;
    flicker_irq_en_nxt = flicker_irq_en_r;
    mux_done_irq_en_nxt = mux_done_irq_en_r;
    rdata_nxt = rdata_r;
    rd_valid_nxt = 1'b0;
    // Reserved bits are never stored, so a careless write cannot disturb them.
    if (REG_WR && own_hit) begin
      unique case (REG_ADDR)
        MCR_ADDR_CFG_ZERO: begin
          low_power_nxt = REG_WDATA[MCR_BIT_LOW_POWER];
          bank_sel_nxt = REG_WDATA[MCR_BIT_BANK_SEL];
          wait_stretch_nxt = REG_WDATA[MCR_BIT_WAIT_STRETCH];
        end
        MCR_ADDR_SLEEP_CTL: begin
          sleep_on_irq_nxt = REG_WDATA[MCR_BIT_SLEEP_ON_IRQ];
        end
        MCR_ADDR_MUX_CFG: begin
          mux_cmd_cfg_nxt = REG_WDATA[MCR_MUX_CMD_MSB:MCR_MUX_CMD_LSB];
        end
        default: begin
          flicker_irq_en_nxt = REG_WDATA[MCR_BIT_FLICKER_IRQ_EN];
          mux_done_irq_en_nxt = REG_WDATA[MCR_BIT_MUX_DONE_IRQ_EN];
        end
      endcase
    end
    // Reads of this bank are answered one cycle later with reserved bits shown.
    if (REG_RD && own_hit) begin
      rd_valid_nxt = 1'b1;
      rdata_nxt = 8'h00;
      unique case (REG_ADDR)
        MCR_ADDR_CFG_ZERO: begin
          rdata_nxt[MCR_BIT_LOW_POWER] = low_power_r;
          rdata_nxt[MCR_BIT_BANK_SEL] = bank_sel_r;
          rdata_nxt[MCR_BIT_WAIT_STRETCH] = wait_stretch_r;
        end
        MCR_ADDR_SLEEP_CTL: begin
          rdata_nxt[MCR_BIT_SLEEP_ON_IRQ] = sleep_on_irq_r;
          rdata_nxt[MCR_SLEEP_RSVD_MSB:0] = MCR_SLEEP_RSVD_VAL;
        end
        MCR_ADDR_MUX_CFG: begin
          rdata_nxt[MCR_MUX_CMD_MSB:MCR_MUX_CMD_LSB] = mux_cmd_cfg_r;
        end
        default: begin
          rdata_nxt[MCR_BIT_FLICKER_IRQ_EN] = flicker_irq_en_r;
          rdata_nxt[MCR_BIT_MUX_DONE_IRQ_EN] = mux_done_irq_en_r;
        end
      endcase
    end
  end

  // Bank steering of each other access in the selected window towards the upper or alternate set.
  always_comb begin
    fwd_upper_nxt = 1'b0;
    fwd_alt_nxt = 1'b0;
    fwd_addr_nxt = fwd_addr_r;
    fwd_wdata_nxt = fwd_wdata_r;
    fwd_wr_nxt = fwd_wr_r;
    if (access && !own_hit) begin
      if (!bank_sel_r && (REG_ADDR >= MCR_UPPER_LO)) begin
        fwd_upper_nxt = 1'b1;
      end else if (bank_sel_r && in_alt(REG_ADDR)) begin
        fwd_alt_nxt = 1'b1;
      end
      // Address and data are held from the last steered access only.
      if (fwd_upper_nxt || fwd_alt_nxt) begin
        fwd_addr_nxt = REG_ADDR;
        fwd_wdata_nxt = REG_WDATA;
        fwd_wr_nxt = REG_WR;
      end
    end
  end

  // Register the configuration fields and the access answers.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      low_power_r <= 1'b0;
      bank_sel_r <= 1'b0;
      wait_stretch_r <= 1'b0;
      sleep_on_irq_r <= 1'b0;
      mux_cmd_cfg_r <= MCR_MUX_CMD_RST;
      flicker_irq_en_r <= 1'b0;
      mux_done_irq_en_r <= 1'b0;
      rdata_r <= 8'h00;
      rd_valid_r <= 1'b0;
      fwd_upper_r <= 1'b0;
      fwd_alt_r <= 1'b0;
      fwd_addr_r <= 8'h00;
      fwd_wdata_r <= 8'h00;
      fwd_wr_r <= 1'b0;
    end else if (CE) begin
      low_power_r <= low_power_nxt;
      bank_sel_r <= bank_sel_nxt;
      wait_stretch_r <= wait_stretch_nxt;
      sleep_on_irq_r <= sleep_on_irq_nxt;
      mux_cmd_cfg_r <= mux_cmd_cfg_nxt;
      flicker_irq_en_r <= flicker_irq_en_nxt;
      mux_done_irq_en_r <= mux_done_irq_en_nxt;
      rdata_r <= rdata_nxt;
      rd_valid_r <= rd_valid_nxt;
      fwd_upper_r <= fwd_upper_nxt;
      fwd_alt_r <= fwd_alt_nxt;
      fwd_addr_r <= fwd_addr_nxt;
      fwd_wdata_r <= fwd_wdata_nxt;
      fwd_wr_r <= fwd_wr_nxt;
    end
  end

  // Wait period and low power request.
  logic [MCR_WAIT_STEPS_W-1:0] wait_steps_r; // Wait period in base steps.
  logic [MCR_WAIT_STEPS_W-1:0] wait_steps_nxt;
  logic [MCR_WAIT_STEPS_W-1:0] wait_base; // One step more than the setting.
  logic low_power_idle_r; // Low power request towards the power manager.
  logic low_power_idle_nxt;

  // The stretch is a plain shift, so the result is exact and needs no multiplier.
  always_comb begin
    wait_base = MCR_WAIT_STEPS_W'(WAIT_TIME_SETTING) + MCR_WAIT_ONE;
    if (wait_stretch_r) begin
      wait_steps_nxt = wait_base << MCR_WAIT_STRETCH_SHIFT;
    end else begin
      wait_steps_nxt = wait_base;
    end
    low_power_idle_nxt = low_power_r && ALL_IDLE;
  end

  // Register the wait period and the low power request.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      wait_steps_r <= MCR_WAIT_ONE;
      low_power_idle_r <= 1'b0;
    end else if (CE) begin
      wait_steps_r <= wait_steps_nxt;
      low_power_idle_r <= low_power_idle_nxt;
    end
  end

  // Chain command sequencer and system interrupt pulses.
  mcr_mux_st_t mux_st_r; // Sequencer state.
  mcr_mux_st_t mux_st_nxt;
  logic [1:0] mux_cmd_r; // Command captured at the go.
  logic [1:0] mux_cmd_nxt;
  logic mux_start_r; // One-cycle start strobe to the chain.
  logic mux_start_nxt;
  logic flicker_prev_r; // Flicker status seen in the previous cycle.
  logic irq_flicker_r;
  logic irq_flicker_nxt;
  logic irq_mux_r;
  logic irq_mux_nxt;
  logic mux_busy_r; // Busy level, kept in its own flop so the port needs no decode.
  logic mux_busy_nxt; // Next value of the busy level.

  // The command is captured at the go, so a change made during the run cannot
  // disturb it; a go with the reserved code is dropped and starts nothing.
  always_comb begin
    mux_st_nxt = mux_st_r;
    mux_cmd_nxt = mux_cmd_r;
    mux_start_nxt = 1'b0;
    irq_mux_nxt = 1'b0;
    unique case (mux_st_r)
      MCR_MUX_IDLE: begin
        if (MUX_GO_SET && (mux_cmd_cfg_r != MCR_CMD_RESERVED)) begin
          mux_st_nxt = MCR_MUX_BUSY;
          mux_cmd_nxt = mux_cmd_cfg_r;
          mux_start_nxt = 1'b1;
        end
      end
      MCR_MUX_BUSY: begin
        // A done strobe outside a run is ignored.
        if (MUX_DONE) begin
          mux_st_nxt = MCR_MUX_IDLE;
          irq_mux_nxt = mux_done_irq_en_r;
        end
      end
    endcase
    irq_flicker_nxt = flicker_irq_en_r && (FLICKER_STATUS != flicker_prev_r);
    mux_busy_nxt = (mux_st_nxt == MCR_MUX_BUSY);
  end

  // Register the sequencer and the interrupt pulses.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      mux_st_r <= MCR_MUX_IDLE;
      mux_cmd_r <= MCR_MUX_CMD_RST;
      mux_start_r <= 1'b0;
      flicker_prev_r <= 1'b0;
      irq_flicker_r <= 1'b0;
      irq_mux_r <= 1'b0;
      mux_busy_r <= 1'b0;
    end else if (CE) begin
      mux_st_r <= mux_st_nxt;
      mux_cmd_r <= mux_cmd_nxt;
      mux_start_r <= mux_start_nxt;
      flicker_prev_r <= FLICKER_STATUS;
      irq_flicker_r <= irq_flicker_nxt;
      irq_mux_r <= irq_mux_nxt;
      mux_busy_r <= mux_busy_nxt;
    end
  end

  // Sleep-after-interrupt control of the oscillator.
  logic sleep_flag; // Sleep flag from the controller flop.
  logic osc_run; // Oscillator run request from the controller flop.

  mcr_sleep_ctl u_sleep (
    .clk(CLK),
    .rst_b(RST_B),
    .ce(CE),
    .sleep_en(sleep_on_irq_r),
    .irq_active(IRQ_ACTIVE),
    .flag_clr(SLEEP_FLAG_CLR),
    .flag_r(sleep_flag),
    .osc_run_r(osc_run)
  );

  // Every output is a flop of this module or of the sleep controller.
  assign REG_RDATA = rdata_r;
  assign REG_RD_VALID = rd_valid_r;
  assign FWD_UPPER = fwd_upper_r;
  assign FWD_ALT = fwd_alt_r;
  assign FWD_ADDR = fwd_addr_r;
  assign FWD_WDATA = fwd_wdata_r;
  assign FWD_WR = fwd_wr_r;
  assign WAIT_STEPS = wait_steps_r;
  assign SLEEP_FLAG = sleep_flag;
  assign OSC_RUN = osc_run;
  assign MUX_START = mux_start_r;
  assign MUX_CMD = mux_cmd_r;
  assign MUX_BUSY = mux_busy_r;
  assign SYS_IRQ_FLICKER = irq_flicker_r;
  assign SYS_IRQ_MUX = irq_mux_r;
  assign LOW_POWER_IDLE = low_power_idle_r;

endmodule

// *** mcr_host.sv ***
`timescale 1ns/10ps
// Host side of the register bus: one request per call, driven off the falling edge.
module mcr_host (
  input wire logic clk,
  input wire logic rd_valid,
  input wire logic fwd_upper,
  input wire logic fwd_alt,
  input wire logic [7:0] rdata,
  output logic [7:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd
);
  // The bus starts idle.
  initial begin
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'h0;
    rd = 1'h0;
  end

  // Sleep control byte that keeps the reserved nibble at its reset value.
  function automatic logic [7:0] sleep_byte(input logic on);
    return {3'h0, on, 4'hC};
  endfunction

  // Chain command byte; the reserved code is never sent.
  function automatic logic [7:0] cmd_byte(input logic [1:0] c);
    return {3'h0, (c == 2'h3) ? 2'h2 : c, 3'h0};
  endfunction

  // The answer is registered at the taking edge itself, so it is read at the next fall.
  // Released lines show the inverse, so a stale address can never look valid.
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [10:0] seen);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = w;
    rd = !w;
    @(negedge clk);
    seen = {rd_valid, fwd_upper, fwd_alt, rdata};
    wr = 1'h0;
    rd = 1'h0;
    addr = ~a;
    wdata = ~d;
  endtask
endmodule

// *** mcr_properties.sv ***
`timescale 1ns/10ps
// Port-level checks of the configuration bank.
module mcr_properties
  import mcr_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic CE,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic FWD_UPPER,
  input wire logic FWD_ALT,
  input wire logic [7:0] FWD_ADDR,
  input wire logic [7:0] WAIT_TIME_SETTING,
  input wire logic [12:0] WAIT_STEPS,
  input wire logic IRQ_ACTIVE,
  input wire logic SLEEP_FLAG_CLR,
  input wire logic SLEEP_FLAG,
  input wire logic OSC_RUN,
  input wire logic MUX_GO_SET,
  input wire logic MUX_DONE,
  input wire logic MUX_START,
  input wire logic [1:0] MUX_CMD,
  input wire logic MUX_BUSY,
  input wire logic FLICKER_STATUS,
  input wire logic SYS_IRQ_FLICKER,
  input wire logic SYS_IRQ_MUX,
  input wire logic ALL_IDLE,
  input wire logic LOW_POWER_IDLE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);

  logic bank_r, stretch_r, lp_r, sleep_r, fd_r, md_r; // Mirror of the stored fields.
  logic [1:0] cmd_r; // Mirror of the chain command.
  logic req; // A request is taken this edge.
  logic own; // The address is one of the bank's own registers.
  assign req = CE && (REG_WR || REG_RD);
  assign own = REG_ADDR inside {MCR_ADDR_CFG_ZERO, MCR_ADDR_SLEEP_CTL, MCR_ADDR_MUX_CFG,
                                MCR_ADDR_IRQ_EN};

  // The mirror follows host writes, so the checks need no view inside the design.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      {lp_r, bank_r, stretch_r, sleep_r, fd_r, md_r} <= 6'h00;
      cmd_r <= MCR_MUX_CMD_RST;
    end else if (CE && REG_WR) begin
      case (REG_ADDR)
        MCR_ADDR_CFG_ZERO: {lp_r, bank_r, stretch_r} <= {REG_WDATA[5:4], REG_WDATA[2]};
        MCR_ADDR_SLEEP_CTL: sleep_r <= REG_WDATA[4];
        MCR_ADDR_MUX_CFG: cmd_r <= REG_WDATA[4:3];
        MCR_ADDR_IRQ_EN: {fd_r, md_r} <= {REG_WDATA[6], REG_WDATA[4]};
        default: ;
      endcase
    end
  end

  sequence s_go;
    MUX_GO_SET && !MUX_BUSY && cmd_r != MCR_CMD_RESERVED;
  endsequence
  sequence s_run;
    MUX_START && MUX_BUSY && MUX_CMD == $past(cmd_r) ##1 !MUX_START;
  endsequence

  property p_upper;
    req && !own && !bank_r && REG_ADDR >= MCR_UPPER_LO |=> FWD_UPPER && FWD_ADDR == $past(REG_ADDR);
  endproperty
  a_upper: assert property (p_upper) else $error("upper access not steered");
  property p_alt;
    req && !own && bank_r && REG_ADDR inside {[MCR_ALT_LO:MCR_ALT_HI]} |=> FWD_ALT && !FWD_UPPER;
  endproperty
  a_alt: assert property (p_alt) else $error("alternate access not steered");
  property p_no_upper;
    req && bank_r && REG_ADDR >= MCR_UPPER_LO |=> !FWD_UPPER && !FWD_ALT;
  endproperty
  a_no_upper: assert property (p_no_upper) else $error("upper set reached in bank one");
  property p_wait;
    $past(RST_B) |-> WAIT_STEPS ==
      (({5'h00, $past(WAIT_TIME_SETTING)} + MCR_WAIT_ONE) << ($past(stretch_r) ? 4 : 0));
  endproperty
  a_wait: assert property (p_wait) else $error("wait steps wrong");
  property p_sleep;
    sleep_r && IRQ_ACTIVE |=> SLEEP_FLAG && !OSC_RUN;
  endproperty
  a_sleep: assert property (p_sleep) else $error("oscillator not stopped");
  property p_hold;
    SLEEP_FLAG && IRQ_ACTIVE |=> SLEEP_FLAG [*2];
  endproperty
  a_hold: assert property (p_hold) else $error("flag lost while pending");
  property p_wake;
    SLEEP_FLAG && SLEEP_FLAG_CLR && !IRQ_ACTIVE |=> !SLEEP_FLAG && OSC_RUN;
  endproperty
  a_wake: assert property (p_wake) else $error("oscillator not resumed");
  property p_go;
    s_go |=> s_run;
  endproperty
  a_go: assert property (p_go) else $error("chain start wrong");
  property p_busy;
    MUX_BUSY && MUX_GO_SET && !MUX_DONE |=> !MUX_START && MUX_BUSY;
  endproperty
  a_busy: assert property (p_busy) else $error("go taken while busy");
  property p_done;
    MUX_BUSY && MUX_DONE |=> !MUX_BUSY && SYS_IRQ_MUX == $past(md_r);
  endproperty
  a_done: assert property (p_done) else $error("chain completion wrong");
  property p_flick;
    fd_r && $changed(FLICKER_STATUS) |-> ##[1:2] SYS_IRQ_FLICKER;
  endproperty
  a_flick: assert property (p_flick) else $error("flicker interrupt missing");
  property p_lowp;
    $past(RST_B) |-> LOW_POWER_IDLE == ($past(lp_r) && $past(ALL_IDLE));
  endproperty
  a_lowp: assert property (p_lowp) else $error("low power idle wrong");
endmodule

// *** tb.sv ***
`timescale 1ns/10ps
// Bench for the configuration bank; nets carry the port names so the .* connection of dut can use them.
module tb;
  import mcr_pkg::*;
  logic CLK = 1'h0;
  logic RST_B = 1'h0;
  logic CE = 1'h1; // Clock enable; lowered once near the end to check the freeze.
  logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA, FWD_ADDR, FWD_WDATA, WAIT_TIME_SETTING;
  logic [12:0] WAIT_STEPS;
  logic [1:0] MUX_CMD;
  logic REG_WR, REG_RD, REG_RD_VALID, FWD_UPPER, FWD_ALT, FWD_WR, IRQ_ACTIVE, SLEEP_FLAG_CLR;
  logic SLEEP_FLAG, OSC_RUN, MUX_GO_SET, MUX_DONE, MUX_START, MUX_BUSY, FLICKER_STATUS;
  logic SYS_IRQ_FLICKER, SYS_IRQ_MUX, ALL_IDLE, LOW_POWER_IDLE;
  int fail_count = 0;
  int n_checks = 0;
  int cycles = 0;
  int pulses;
  logic [10:0] seen; // Valid, upper, alternate strobes and read data.
  logic [24:0] rows [12]; // Write flag, address, write data, expected read.

  always #10 CLK = ~CLK;

  mcr_top dut (.*);
  mcr_host host (.clk(CLK), .rd_valid(REG_RD_VALID), .fwd_upper(FWD_UPPER), .fwd_alt(FWD_ALT),
    .rdata(REG_RDATA), .addr(REG_ADDR), .wdata(REG_WDATA), .wr(REG_WR), .rd(REG_RD));

  // Compares and counts.
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, got, exp);
    end
  endtask

  // Prints the counts and the verdict.
  task automatic results;
    $display("Checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Cuts a hang short; the run needs well under a thousand cycles.
  always @(posedge CLK) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count++;
      results();
    end
  end

  // Pulses one input for a single cycle, from fall to fall.
  task automatic go(input int which);
    if (which == 0) MUX_GO_SET = 1'h1;
    else if (which == 1) MUX_DONE = 1'h1;
    else SLEEP_FLAG_CLR = 1'h1;
    @(negedge CLK);
    // Only the pulsed line is lowered, so a following call never writes it twice at once.
    if (which == 0) MUX_GO_SET = 1'h0;
    else if (which == 1) MUX_DONE = 1'h0;
    else SLEEP_FLAG_CLR = 1'h0;
  endtask

  initial begin
    {IRQ_ACTIVE, SLEEP_FLAG_CLR, MUX_GO_SET, MUX_DONE, FLICKER_STATUS, ALL_IDLE} = 6'h00;
    WAIT_TIME_SETTING = 8'h00;
    rows = '{{1'h0, 8'hA9, 8'h00, 8'h00}, {1'h0, 8'hAC, 8'h00, 8'h0C}, {1'h0, 8'hAF, 8'h00, 8'h10},
      {1'h0, 8'hB2, 8'h00, 8'h00}, {1'h1, 8'hA9, 8'hFF, 8'h34}, {1'h1, 8'hA9, 8'h00, 8'h00},
      {1'h1, 8'hAC, 8'h1C, 8'h1C}, {1'h1, 8'hAC, 8'h0C, 8'h0C}, {1'h1, 8'hAF, 8'h00, 8'h00},
      {1'h1, 8'hAF, 8'h10, 8'h10}, {1'h1, 8'hB2, 8'hFF, 8'h50}, {1'h1, 8'hB2, 8'h00, 8'h00}};
    repeat (8) @(negedge CLK);
    RST_B = 1'h1;
    check({OSC_RUN, SLEEP_FLAG, MUX_BUSY, MUX_START, MUX_CMD}, 6'h22);
    check(WAIT_STEPS, 13'h0001);
    // Reset values and readback, reserved bits never stored.
    foreach (rows[i]) begin
      if (rows[i][24]) host.acc(1'h1, rows[i][23:16], rows[i][15:8], seen);
      host.acc(1'h0, rows[i][23:16], 8'h00, seen);
      check(seen, {3'h4, rows[i][7:0]});
    end
    // Steering between the two windows, at their edges.
    host.acc(1'h0, 8'h80, 8'h00, seen);
    check({seen[10:8], FWD_ADDR}, {3'h2, 8'h80});
    host.acc(1'h0, 8'h60, 8'h00, seen);
    check(seen[10:8], 3'h0);
    host.acc(1'h1, MCR_ADDR_CFG_ZERO, 8'h10, seen);
    host.acc(1'h1, 8'h74, 8'h5A, seen);
    check({seen[10:8], FWD_WR, FWD_WDATA}, {3'h1, 1'h1, 8'h5A});
    host.acc(1'h0, 8'h75, 8'h00, seen);
    check(seen[10:8], 3'h0);
    host.acc(1'h0, 8'hFF, 8'h00, seen);
    check(seen[10:8], 3'h0);
    // Stretched wait at the largest setting, then plain wait with low power idle on.
    host.acc(1'h1, MCR_ADDR_CFG_ZERO, 8'h04, seen);
    WAIT_TIME_SETTING = 8'hFF;
    repeat (2) @(negedge CLK);
    check(WAIT_STEPS, 13'h1000);
    host.acc(1'h1, MCR_ADDR_CFG_ZERO, 8'h20, seen);
    ALL_IDLE = 1'h1;
    repeat (2) @(negedge CLK);
    check({WAIT_STEPS, LOW_POWER_IDLE}, {13'h0100, 1'h1});
    ALL_IDLE = 1'h0;
    repeat (2) @(negedge CLK);
    check(LOW_POWER_IDLE, 1'h0);
    // Sleep after interrupt: a clear while pending is ignored.
    host.acc(1'h1, MCR_ADDR_SLEEP_CTL, host.sleep_byte(1'h1), seen);
    IRQ_ACTIVE = 1'h1;
    repeat (2) @(negedge CLK);
    check({SLEEP_FLAG, OSC_RUN}, 2'h2);
    go(2);
    check({SLEEP_FLAG, OSC_RUN}, 2'h2);
    IRQ_ACTIVE = 1'h0;
    repeat (2) @(negedge CLK);
    check({SLEEP_FLAG, OSC_RUN}, 2'h2);
    go(2);
    check({SLEEP_FLAG, OSC_RUN}, 2'h1);
    // Each non-reserved chain command, a refused go while busy, completion interrupt.
    host.acc(1'h1, MCR_ADDR_IRQ_EN, 8'h10, seen);
    for (int c = 0; c < 3; c++) begin
      host.acc(1'h1, MCR_ADDR_MUX_CFG, host.cmd_byte(c[1:0]), seen);
      go(0);
      check({MUX_START, MUX_BUSY, MUX_CMD}, {2'h3, c[1:0]});
      // Let an edge pass so the second go is a fresh pulse.
      @(negedge CLK);
      go(0);
      check({MUX_START, MUX_BUSY}, 2'h1);
      go(1);
      check({MUX_BUSY, SYS_IRQ_MUX}, 2'h1);
    end
    // Flicker change with the enable on, then off.
    host.acc(1'h1, MCR_ADDR_IRQ_EN, 8'h40, seen);
    for (int e = 0; e < 2; e++) begin
      pulses = 0;
      FLICKER_STATUS = ~FLICKER_STATUS;
      repeat (4) begin
        @(negedge CLK);
        pulses += SYS_IRQ_FLICKER;
      end
      check(pulses[3:0], (e == 0) ? 4'h1 : 4'h0);
      host.acc(1'h1, MCR_ADDR_IRQ_EN, 8'h00, seen);
    end
    // Clock enable low: a bank write and a read are both ignored.
    CE = 1'h0;
    host.acc(1'h1, MCR_ADDR_CFG_ZERO, 8'h10, seen);
    host.acc(1'h0, MCR_ADDR_CFG_ZERO, 8'h00, seen);
    check(seen[10:8], 3'h0);
    CE = 1'h1;
    host.acc(1'h0, 8'h80, 8'h00, seen);
    check({seen[10:8], FWD_ADDR}, {3'h2, 8'h80});
    // Reset in mid-run returns the outputs and the stored fields to their reset values.
    RST_B = 1'h0;
    @(negedge CLK);
    check({OSC_RUN, SLEEP_FLAG, MUX_BUSY, MUX_START, MUX_CMD}, 6'h22);
    check(WAIT_STEPS, 13'h0001);
    RST_B = 1'h1;
    host.acc(1'h0, MCR_ADDR_CFG_ZERO, 8'h00, seen);
    check(seen, {3'h4, 8'h00});
    results();
  end
endmodule

bind mcr_top mcr_properties u_props (.*);
